// ==== common/hpa_map.vh ====
// hpa_map.vh: register offsets, access-type codes, field positions and reset values
// for the host parallel access port; included by the port core and the bench by bare name
`ifndef HPA_MAP_VH
`define HPA_MAP_VH

`define HPA_OFS_CONTROL        32'h01880000
`define HPA_OFS_WRITE_ADDRESS  32'h01880004
`define HPA_OFS_READ_ADDRESS   32'h01880008
`define HPA_OFS_TRANSFER_CTL   32'h018a0000

`define HPA_TYPE_CONTROL       2'h0
`define HPA_TYPE_DATA_INC      2'h1
`define HPA_TYPE_ADDRESS       2'h2
`define HPA_TYPE_DATA_FIXED    2'h3

`define HPA_CTRL_HALF_ORDER    0
`define HPA_CTRL_WRITE_PEND    3
`define HPA_CTRL_WMASK         32'hfffffff7

`define HPA_RST_CONTROL        32'h00000000
`define HPA_RST_ADDRESS        32'h00000000
`define HPA_RST_TRANSFER_CTL   32'h00000000

`define HPA_ADDR_STEP          32'h00000004
`define HPA_FIFO_DEPTH         16
`define HPA_SYNC_WIDTH         40

`endif

// ==== core/hpa_fifo.v ====
// hpa_fifo.v: synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock and an already synchronised active-low reset
`default_nettype none

module hpa_fifo #(
  parameter WIDTH  = 64,
  parameter DEPTH  = 16,
  parameter ADDR_W = 4
) (
  input  wire             i_clock,
  input  wire             i_rst_n,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0]  mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr;
  reg [ADDR_W-1:0] rd_ptr;
  reg [ADDR_W:0]   count;
  wire             push;
  wire             pop;

  assign o_in_ready  = (count != DEPTH[ADDR_W:0]);
  assign o_out_valid = (count != {(ADDR_W+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always @(posedge i_clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers wrap by depth so depth need not be a power of two
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= {ADDR_W{1'b0}};
      rd_ptr <= {ADDR_W{1'b0}};
      count  <= {(ADDR_W+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop & ~push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== core/hpa_port.v ====
// hpa_port.v: host parallel access port, host pins to internal dma requests,
// plus the internal processor's view of the port registers
// assumes host pins are asynchronous; dma and processor ports share i_clock
`include "hpa_map.vh"
`default_nettype none

// Overview of operation
// - strobe is not(xor of data strobes) or select
// - host starts every transfer, port only answers
// - memory accesses go through dma requests
// - any address reachable, peripherals and memories alike
// - host address write loads both copies
// - processor sees two independent address copies
// - data register only reachable from host
// - control register read/write by host and processor
// - word or first half-word data read fetches; wait held until loaded
// - data write waits while write buffer full
// - drive bus after strobe falls, release after rise
// - address strobe optional, tied high allowed
module hpa_port #(
  parameter FIFO_DEPTH = `HPA_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  input  wire        i_clock,
  input  wire        i_nrst,
  input  wire        i_half_word_bus_mode,
  input  wire        i_port_chip_select_n,
  input  wire        i_data_strobe_one,
  input  wire        i_data_strobe_two,
  input  wire        i_address_strobe_n,
  input  wire [1:0]  i_access_type_select,
  input  wire        i_read_not_write,
  input  wire        i_half_word_select,
  input  wire [31:0] i_port_data_bus,
  output reg  [31:0] o_port_data_bus,
  output reg         o_port_data_oe,
  output reg         o_port_wait_n,
  input  wire        i_cpu_req,
  input  wire        i_cpu_write,
  input  wire [31:0] i_cpu_addr,
  input  wire [31:0] i_cpu_wdata,
  output reg         o_cpu_ack,
  output reg  [31:0] o_cpu_rdata,
  output reg         o_dma_req,
  output reg         o_dma_write,
  output reg  [31:0] o_dma_addr,
  output reg  [31:0] o_dma_wdata,
  input  wire        i_dma_ack,
  input  wire [31:0] i_dma_rdata
);
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_DONE  = 3'h4;

  reg  [1:0]                 rst_sync;
  wire                       rst_n;
  reg  [`HPA_SYNC_WIDTH-1:0] pin_meta;
  reg  [`HPA_SYNC_WIDTH-1:0] pin_sync;
  reg                        mode_meta;
  reg                        mode_sync;
  wire                       strobe_n;
  reg                        strobe_q;
  reg                        addr_strobe_q;
  wire                       strobe_fall;
  wire                       strobe_rise;
  wire                       addr_strobe_fall;
  reg                        sel_held;
  reg  [3:0]                 sel_latch;
  reg  [3:0]                 sel;
  wire [3:0]                 sel_now;
  wire [3:0]                 sel_take;
  wire                       take_data;
  reg  [2:0]                 state;
  reg  [31:0]                control;
  reg  [31:0]                write_address;
  reg  [31:0]                read_address;
  reg  [31:0]                transfer_ctl;
  reg  [31:0]                read_word;
  reg  [31:0]                write_word;
  reg                        fetch_req;
  wire                       is_data;
  wire                       hw_mode;
  wire                       first_half;
  wire                       upper_half;
  wire [31:0]                host_in;
  wire [31:0]                merged_write;
  wire [31:0]                merged_addr;
  wire [31:0]                merged_ctrl;
  wire                       word_done;
  wire                       push;
  wire                       fifo_in_ready;
  wire                       fifo_out_valid;
  wire [63:0]                fifo_out_data;
  wire                       drain;
  reg  [31:0]                read_src;

  // reset release through two flops, assertion stays asynchronous
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // all host pins pass two flops; data shares the strobe's latency so they stay aligned
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta  <= {`HPA_SYNC_WIDTH{1'b1}};
      pin_sync  <= {`HPA_SYNC_WIDTH{1'b1}};
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end
    else
    begin
      mode_meta <= i_half_word_bus_mode;
      mode_sync <= mode_meta;
      pin_meta <= {i_port_chip_select_n, i_data_strobe_one, i_data_strobe_two,
                   i_address_strobe_n, i_access_type_select, i_read_not_write,
                   i_half_word_select, i_port_data_bus};
      pin_sync <= pin_meta;
    end
  end

  assign strobe_n         = ~(pin_sync[38] ^ pin_sync[37]) | pin_sync[39];
  assign host_in          = pin_sync[31:0];
  assign sel_now          = pin_sync[35:32];
  assign strobe_fall      = strobe_q & ~strobe_n;
  assign strobe_rise      = ~strobe_q & strobe_n;
  assign addr_strobe_fall = addr_strobe_q & ~pin_sync[36];

  // sel = {type[1:0], read_not_write, half_word_select}
  assign hw_mode    = mode_sync;
  assign is_data    = sel[3] ^ sel[2] ? (sel[3:2] == `HPA_TYPE_DATA_INC) : (sel[3:2] == `HPA_TYPE_DATA_FIXED);
  // decode what the fall is about to latch; sel itself only updates at that edge
  assign sel_take   = sel_held ? sel_latch : sel_now;
  assign take_data  = (sel_take[3:2] == `HPA_TYPE_DATA_INC)
                      | (sel_take[3:2] == `HPA_TYPE_DATA_FIXED);
  assign first_half = ~hw_mode | ~sel_take[0];
  assign upper_half = hw_mode & ~(sel[0] ^ control[`HPA_CTRL_HALF_ORDER]);
  assign word_done  = ~hw_mode | sel[0];
  assign merged_write = ~hw_mode ? host_in : upper_half ?
                        {host_in[15:0], write_word[15:0]} : {write_word[31:16], host_in[15:0]};
  assign merged_addr  = ~hw_mode ? host_in : upper_half ?
                        {host_in[15:0], write_address[15:0]} : {write_address[31:16], host_in[15:0]};
  assign merged_ctrl  = ~hw_mode ? host_in : upper_half ?
                        {host_in[15:0], control[15:0]} : {control[31:16], host_in[15:0]};
  // a full buffer holds the push back; the host is kept waiting meanwhile
  assign push  = (state == ST_DONE) & strobe_rise & is_data & ~sel[1] & word_done
                 & fifo_in_ready;
  // writes drain ahead of any fetch so a read never overtakes buffered writes
  assign drain = ~o_dma_req & fifo_out_valid;

  always @*
  begin
    case (sel[3:2])
      `HPA_TYPE_CONTROL: read_src = control;
      `HPA_TYPE_ADDRESS: read_src = read_address;
      default:           read_src = read_word;
    endcase
  end

  // selects come from the address strobe when it pulsed, else from the access strobe
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_q      <= 1'b1;
      addr_strobe_q <= 1'b1;
      sel_held      <= 1'b0;
      sel_latch     <= 4'h0;
      sel           <= 4'h0;
    end
    else
    begin
      strobe_q      <= strobe_n;
      addr_strobe_q <= pin_sync[36];
      if (addr_strobe_fall)
      begin
        sel_held  <= 1'b1;
        sel_latch <= sel_now;
      end
      else if (strobe_rise)
      begin
        sel_held <= 1'b0;
      end
      if (strobe_fall)
      begin
        sel <= sel_take;
      end
    end
  end

  // access sequencer: idle, fetch from memory, then answered until the strobe rises
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= ST_IDLE;
      fetch_req      <= 1'b0;
      o_port_wait_n  <= 1'b0;
      o_port_data_oe <= 1'b0;
      o_port_data_bus <= 32'h00000000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          o_port_wait_n <= 1'b0;
          if (strobe_fall)
          begin
            state <= ST_DONE;
            if (take_data & sel_take[1] & first_half)
            begin
              state         <= ST_FETCH;
              fetch_req     <= 1'b1;
              o_port_wait_n <= 1'b1;
            end
            else if (take_data & ~sel_take[1] & ~fifo_in_ready)
            begin
              o_port_wait_n <= 1'b1;
            end
          end
        end
        ST_FETCH:
        begin
          if (o_dma_req & ~o_dma_write & i_dma_ack)
          begin
            fetch_req <= 1'b0;
            state     <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          o_port_wait_n <= is_data & ~sel[1] & ~fifo_in_ready;
          if (sel[1])
          begin
            o_port_data_oe  <= ~strobe_n;
            o_port_data_bus <= ~hw_mode ? read_src :
                               {16'h0000, upper_half ? read_src[31:16] : read_src[15:0]};
          end
          if (strobe_rise)
          begin
            state          <= ST_IDLE;
            o_port_data_oe <= 1'b0;
            o_port_wait_n  <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // dma side: one request at a time, held until acknowledged
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_dma_req   <= 1'b0;
      o_dma_write <= 1'b0;
      o_dma_addr  <= 32'h00000000;
      o_dma_wdata <= 32'h00000000;
      read_word   <= 32'h00000000;
    end
    else
    begin
      if (o_dma_req & i_dma_ack)
      begin
        o_dma_req <= 1'b0;
        if (~o_dma_write)
        begin
          read_word <= i_dma_rdata;
        end
      end
      else if (drain)
      begin
        o_dma_req   <= 1'b1;
        o_dma_write <= 1'b1;
        o_dma_addr  <= fifo_out_data[63:32];
        o_dma_wdata <= fifo_out_data[31:0];
      end
      else if (~o_dma_req & fetch_req & (state == ST_FETCH))
      begin
        o_dma_req   <= 1'b1;
        o_dma_write <= 1'b0;
        o_dma_addr  <= read_address;
      end
    end
  end

  // registers; a host write in the same cycle as a processor write wins
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control       <= `HPA_RST_CONTROL;
      write_address <= `HPA_RST_ADDRESS;
      read_address  <= `HPA_RST_ADDRESS;
      transfer_ctl  <= `HPA_RST_TRANSFER_CTL;
      write_word    <= 32'h00000000;
      o_cpu_ack     <= 1'b0;
      o_cpu_rdata   <= 32'h00000000;
    end
    else
    begin
      o_cpu_ack <= i_cpu_req;
      if (i_cpu_req & i_cpu_write)
      begin
        case (i_cpu_addr)
          `HPA_OFS_CONTROL:       control       <= i_cpu_wdata & `HPA_CTRL_WMASK;
          `HPA_OFS_WRITE_ADDRESS: write_address <= i_cpu_wdata;
          `HPA_OFS_READ_ADDRESS:  read_address  <= i_cpu_wdata;
          `HPA_OFS_TRANSFER_CTL:  transfer_ctl  <= i_cpu_wdata;
          default:                transfer_ctl  <= transfer_ctl;
        endcase
      end
      if (i_cpu_req & ~i_cpu_write)
      begin
        case (i_cpu_addr)
          `HPA_OFS_CONTROL:       o_cpu_rdata <= control;
          `HPA_OFS_WRITE_ADDRESS: o_cpu_rdata <= write_address;
          `HPA_OFS_READ_ADDRESS:  o_cpu_rdata <= read_address;
          `HPA_OFS_TRANSFER_CTL:  o_cpu_rdata <= transfer_ctl;
          default:                o_cpu_rdata <= 32'h00000000;
        endcase
      end
      control[`HPA_CTRL_WRITE_PEND] <= fifo_out_valid | o_dma_req & o_dma_write;
      if ((state == ST_DONE) & strobe_rise & ~sel[1])
      begin
        case (sel[3:2])
          `HPA_TYPE_CONTROL:
          begin
            control <= merged_ctrl & `HPA_CTRL_WMASK;
          end
          `HPA_TYPE_ADDRESS:
          begin
            write_address <= merged_addr;
            read_address  <= merged_addr;
          end
          default:
          begin
            write_word <= merged_write;
            if (push & (sel[3:2] == `HPA_TYPE_DATA_INC))
            begin
              write_address <= write_address + `HPA_ADDR_STEP;
            end
          end
        endcase
      end
      // autoincrement after the fetched word is taken
      if ((state == ST_FETCH) & o_dma_req & ~o_dma_write & i_dma_ack
          & (sel[3:2] == `HPA_TYPE_DATA_INC))
      begin
        read_address <= read_address + `HPA_ADDR_STEP;
      end
    end
  end

  hpa_fifo #(
    .WIDTH  (64),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_AW)
  ) u_write_buffer (
    .i_clock     (i_clock),
    .i_rst_n     (rst_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({write_address, merged_write}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (drain),
    .o_out_data  (fifo_out_data)
  );
endmodule

`default_nettype wire

// ==== verification/hpa_port_asserts.sv ====
// hpa_port_asserts.sv: concurrent checks on the host pins, cpu port and dma side
// assumes it sees only the ports of hpa_port; bound in below
`default_nettype none
module hpa_port_asserts (
  input wire        i_clock,
  input wire        i_nrst,
  input wire        i_half_word_bus_mode,
  input wire        i_port_chip_select_n,
  input wire        i_data_strobe_one,
  input wire        i_data_strobe_two,
  input wire        i_read_not_write,
  input wire        i_cpu_req,
  input wire [31:0] o_port_data_bus,
  input wire        o_port_data_oe,
  input wire        o_port_wait_n,
  input wire        o_cpu_ack,
  input wire        o_dma_req,
  input wire        o_dma_write,
  input wire [31:0] o_dma_addr,
  input wire        i_dma_ack,
  input wire [31:0] i_dma_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire strobe_n = ~(i_data_strobe_one ^ i_data_strobe_two) | i_port_chip_select_n;
  logic [31:0] fetched;
  always @(posedge i_clock)
    if (i_dma_ack && !o_dma_write)
      fetched <= i_dma_rdata;

  chk_ack_follows: assert property (i_cpu_req |=> o_cpu_ack)
    else $error("cpu request not acknowledged next cycle");
  chk_ack_cause: assert property (o_cpu_ack |-> $past(i_cpu_req))
    else $error("cpu ack without request");
  chk_dma_hold: assert property (o_dma_req && !i_dma_ack |=> o_dma_req && $stable(o_dma_addr))
    else $error("dma request dropped or changed before ack");
  chk_dma_single: assert property (o_dma_req && i_dma_ack |=> !o_dma_req)
    else $error("dma request held past its ack");
  chk_oe_release: assert property (strobe_n [*6] |-> !o_port_data_oe)
    else $error("bus still driven after strobe rise");
  chk_strobe_xnor: assert property ((i_data_strobe_one == i_data_strobe_two) [*6] |-> !o_port_data_oe)
    else $error("bus driven while data strobes agree");
  chk_oe_cause: assert property ($rose(o_port_data_oe) |-> !strobe_n && i_read_not_write)
    else $error("bus driven outside a host read");
  chk_fetch_wait: assert property (o_dma_req && !o_dma_write |-> o_port_wait_n)
    else $error("wait low during data fetch");
  chk_fetch_data: assert property (o_dma_req && i_dma_ack && !o_dma_write && !i_half_word_bus_mode
    |-> ##[1:3] (o_port_data_oe && !o_port_wait_n && o_port_data_bus == fetched))
    else $error("fetched word not presented with ready");

  cov_fetch: cover property (o_dma_req && i_dma_ack && !o_dma_write);
  cov_drain: cover property (o_dma_req && i_dma_ack && o_dma_write);
  cov_full: cover property (o_port_wait_n && !i_read_not_write && !strobe_n);
endmodule

bind hpa_port hpa_port_asserts chk_u (
  .i_clock, .i_nrst, .i_half_word_bus_mode, .i_port_chip_select_n, .i_data_strobe_one,
  .i_data_strobe_two, .i_read_not_write, .i_cpu_req, .o_port_data_bus, .o_port_data_oe,
  .o_port_wait_n, .o_cpu_ack, .o_dma_req, .o_dma_write, .o_dma_addr, .i_dma_ack, .i_dma_rdata
);
`default_nettype wire

// ==== verification/hpa_dma_model.sv ====
// hpa_dma_model.sv: memory answering the port's dma requests after a set delay
// assumes one request at a time, held until acknowledged
`default_nettype none
module hpa_dma_model (
  input  wire logic        i_clock,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [7:0]  i_delay,
  output var  logic        o_ack,
  output var  logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [7:0]  cnt = 8'h0;
  initial
  begin
    for (int k = 0; k < 16; k++)
      mem[k] = 32'ha5000000 + k;
    o_ack = 1'b0;
    o_rdata = 32'h0;
  end
  // read data flips outside the ack cycle, so a sample one cycle late never matches
  always @(posedge i_clock)
  begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack)
    begin
      cnt <= cnt + 8'h1;
      if (cnt >= i_delay)
      begin
        cnt <= 8'h0;
        o_ack <= 1'b1;
        if (i_write)
          mem[i_addr[5:2]] <= i_wdata;
        else
          o_rdata <= mem[i_addr[5:2]];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// tb.sv: self-checking bench for the host port, host and cpu driven here
// assumes hpa_port, hpa_fifo, the dma model and the checker are compiled first
`include "hpa_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0, i_nrst = 1'b0, i_half_word_bus_mode = 1'b0;
  logic        i_port_chip_select_n = 1'b1, i_address_strobe_n = 1'b1;
  logic        i_data_strobe_one = 1'b1, i_data_strobe_two = 1'b1;
  logic        i_read_not_write = 1'b1, i_half_word_select = 1'b0;
  logic        i_cpu_req = 1'b0, i_cpu_write = 1'b0, saw_wait = 1'b0;
  logic [1:0]  i_access_type_select = 2'h0;
  logic [31:0] i_port_data_bus = 32'h0, i_cpu_addr = 32'h0, i_cpu_wdata = 32'h0, rd;
  logic [7:0]  dly = 8'h0;
  wire  [31:0] o_port_data_bus, o_cpu_rdata, o_dma_addr, o_dma_wdata, i_dma_rdata;
  wire         o_port_data_oe, o_port_wait_n, o_cpu_ack, o_dma_req, o_dma_write, i_dma_ack;
  int          errors = 0;
  int          n_compared = 0;

  always #2 i_clock = ~i_clock;

  hpa_port dut_u (
    .i_clock, .i_nrst, .i_half_word_bus_mode, .i_port_chip_select_n, .i_data_strobe_one,
    .i_data_strobe_two, .i_address_strobe_n, .i_access_type_select, .i_read_not_write,
    .i_half_word_select, .i_port_data_bus, .o_port_data_bus, .o_port_data_oe, .o_port_wait_n,
    .i_cpu_req, .i_cpu_write, .i_cpu_addr, .i_cpu_wdata, .o_cpu_ack, .o_cpu_rdata,
    .o_dma_req, .o_dma_write, .o_dma_addr, .o_dma_wdata, .i_dma_ack, .i_dma_rdata
  );
  hpa_dma_model dma_u (
    .i_clock, .i_req(o_dma_req), .i_write(o_dma_write), .i_addr(o_dma_addr),
    .i_wdata(o_dma_wdata), .i_delay(dly), .o_ack(i_dma_ack), .o_rdata(i_dma_rdata)
  );

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cpu(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_cpu_req <= 1'b1;
    i_cpu_write <= wr;
    i_cpu_addr <= a;
    i_cpu_wdata <= d;
    @(posedge i_clock);
    i_cpu_req <= 1'b0;
    @(posedge i_clock);
    check(o_cpu_ack, 1'b1);
    rd = o_cpu_rdata;
  endtask

  // alt: second data strobe and the address strobe, otherwise first strobe alone
  task automatic host(input logic r, input logic [1:0] ty, input logic [31:0] d,
                      input logic hs, input logic alt);
    int n;
    @(posedge i_clock);
    i_read_not_write <= r;
    i_access_type_select <= ty;
    i_half_word_select <= hs;
    i_port_data_bus <= r ? ~i_port_data_bus : d;
    i_address_strobe_n <= ~alt;
    @(posedge i_clock);
    i_port_chip_select_n <= 1'b0;
    i_address_strobe_n <= 1'b1;
    if (alt)
      i_data_strobe_two <= 1'b0;
    else
      i_data_strobe_one <= 1'b0;
    for (n = 0; n < 400 && (n < 8 || o_port_wait_n !== 1'b0); n++)
    begin
      @(posedge i_clock);
      if (o_port_wait_n === 1'b1)
        saw_wait = 1'b1;
    end
    if (n == 400)
    begin
      errors++;
      summarize();
    end
    rd = o_port_data_bus;
    if (r)
      check(o_port_data_oe, 1'b1);
    i_port_chip_select_n <= 1'b1;
    i_data_strobe_one <= 1'b1;
    i_data_strobe_two <= 1'b1;
    repeat (8) @(posedge i_clock);
    check(o_port_data_oe, 1'b0);
  endtask

  task automatic t_regs;
    logic [31:0] ofs [4];
    ofs = '{`HPA_OFS_CONTROL, `HPA_OFS_WRITE_ADDRESS, `HPA_OFS_READ_ADDRESS,
            `HPA_OFS_TRANSFER_CTL};
    for (int k = 0; k < 4; k++)
    begin
      cpu(1'b0, ofs[k], 32'h0);
      check(rd, 32'h0);
    end
    for (int k = 1; k < 4; k++)
      cpu(1'b1, ofs[k], 32'h100 * k);
    for (int k = 1; k < 4; k++)
    begin
      cpu(1'b0, ofs[k], 32'h0);
      check(rd, 32'h100 * k);
    end
    cpu(1'b1, `HPA_OFS_CONTROL, 32'hffffffff);
    cpu(1'b0, `HPA_OFS_CONTROL, 32'h0);
    check(rd, 32'hfffffff7);
    cpu(1'b1, 32'h0188000c, 32'h12345678);
    cpu(1'b0, 32'h0188000c, 32'h0);
    check(rd, 32'h0);
    cpu(1'b1, `HPA_OFS_CONTROL, 32'h2);
  endtask

  task automatic t_host_regs;
    host(1'b0, `HPA_TYPE_ADDRESS, 32'h40, 1'b0, 1'b1);
    cpu(1'b0, `HPA_OFS_WRITE_ADDRESS, 32'h0);
    check(rd, 32'h40);
    cpu(1'b0, `HPA_OFS_READ_ADDRESS, 32'h0);
    check(rd, 32'h40);
    host(1'b1, `HPA_TYPE_CONTROL, 32'h0, 1'b0, 1'b0);
    check(rd, 32'h2);
  endtask

  task automatic t_fetch;
    dly <= 8'h9;
    saw_wait = 1'b0;
    host(1'b1, `HPA_TYPE_DATA_FIXED, 32'h0, 1'b0, 1'b0);
    check(rd, 32'ha5000000);
    check(saw_wait, 1'b1);
    host(1'b1, `HPA_TYPE_DATA_INC, 32'h0, 1'b0, 1'b1);
    check(rd, 32'ha5000000);
    cpu(1'b0, `HPA_OFS_READ_ADDRESS, 32'h0);
    check(rd, 32'h44);
    i_half_word_bus_mode <= 1'b1;
    host(1'b1, `HPA_TYPE_DATA_FIXED, 32'h0, 1'b0, 1'b0);
    check(rd, 32'h0000a500);
    host(1'b1, `HPA_TYPE_DATA_FIXED, 32'h0, 1'b1, 1'b0);
    check(rd, 32'h00000001);
    i_half_word_bus_mode <= 1'b0;
  endtask

  // slow dma so the write buffer fills and the host is held off
  task automatic t_write;
    int n;
    dly <= 8'd200;
    saw_wait = 1'b0;
    for (int k = 0; k < 24; k++)
      host(1'b0, `HPA_TYPE_DATA_INC, 32'hd0000000 + k, 1'b0, k[0]);
    check(saw_wait, 1'b1);
    rd = 32'h8;
    for (n = 0; n < 2000 && rd[3] !== 1'b0; n++)
      cpu(1'b0, `HPA_OFS_CONTROL, 32'h0);
    check(n < 2000, 1'b1);
    if (n == 2000)
      summarize();
    for (int k = 8; k < 24; k++)
      check(dma_u.mem[k % 16], 32'hd0000000 + k);
  endtask

  initial
  begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clock);
    t_regs();
    t_host_regs();
    t_fetch();
    t_write();
    summarize();
  end
endmodule
`default_nettype wire
